// *** tcp_timer_counter.sv ***
// Timer and counter line allocator with AHB-Lite register slave
// How it works
// RULE_01 - Four timers, two counters, separately enabled
// RULE_02 - Enabled units take consecutive lines from offset
// RULE_03 - Pin offset accepts zero through eight
// RULE_04 - Disabled units skip; later units move down
// RULE_05 - Numbering continues from flexible into extended lines
// RULE_06 - Unclaimed lines keep their general-purpose role
// RULE_07 - Excluding clock base removes counter A
// RULE_08 - Clock bases three to six exclude counter A
// RULE_09 - Counter A enable refused under excluding base
// RULE_10 - Excluding base refused while counter A enabled
// RULE_11 - Claimed line direction set, kept after disable
// RULE_12 - Counters count falling edges, 32 bits
// RULE_13 - Read-and-reset returns count before clearing
// RULE_14 - Modes zero to three: PWM and period
// RULE_15 - Modes four to six: duty, firmware counting
// RULE_16 - Modes seven to nine; nine odd timers
// RULE_17 - Modes ten to fourteen; ten is default
// RULE_18 - Counter read captured whole in one edge
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module tcp_timer_counter
   import tcp_pkg::*;
(
   input  wire logic                hclk,       // Bus clock, 50 MHz
   input  wire logic                hresetn,    // Async reset, active low
   input  wire logic                hsel,       // Slave select
   input  wire logic [31:0]         haddr,      // Byte address
   input  wire logic [1:0]          htrans,     // Transfer type
   input  wire logic                hwrite,     // Write when high
   input  wire logic [2:0]          hsize,      // Transfer size
   input  wire logic [31:0]         hwdata,     // Write data
   input  wire logic                hready,     // Bus ready
   output logic [31:0]              hrdata,     // Read data
   output logic                     hreadyout,  // Slave ready
   output logic                     hresp,      // Response, always OKAY
   input  wire logic [N_LINES-1:0]  line_in,    // Line levels
   output logic [N_LINES-1:0]       line_out,   // Line drive levels
   output logic [N_LINES-1:0]       line_oe,    // Line drive enables
   input  wire logic [N_TIMERS-1:0] timer_wave, // Timer output waveforms
   output logic                     irq         // Level interrupt
);

   tcp_state_t               st_reg;
   tcp_state_t               st_next;
   logic [N_UNITS-1:0]       act;
   logic [3:0]               slot [N_UNITS];
   logic [N_UNITS-1:0]       want_out;
   logic [N_UNITS-1:0]       wave_all;
   logic [4:0]               pos;
   logic                     excl;
   logic [1:0]               fall;
   logic                     cin;
   logic [IRQ_W-1:0]         ev;
   logic [IRQ_W-1:0]         wr_clr;
   logic [3:0]               mreq;
   logic [4*N_UNITS-1:0]     map;
   logic                     req_ok;
   logic                     addr_ok;

   assign wave_all  = {2'b00, timer_wave};
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = st_reg.rdata;
   assign line_out  = st_reg.lout;
   assign line_oe   = st_reg.dir;
   assign irq       = st_reg.irq;

   // Which timer modes drive their line
   for (genvar g = 0; g < N_UNITS; g++)
   begin : g_unit
      if (g < N_TIMERS)
      begin : g_tmr
         assign want_out[g] = (st_reg.modes[g] == MODE_PWM16)
                           || (st_reg.modes[g] == MODE_PWM8)
                           || (st_reg.modes[g] == MODE_FREQ_OUT);
      end
      else
      begin : g_ctr
         assign want_out[g] = 1'b0;
      end
   end

   always_comb
   begin
      st_next = st_reg;
      ev      = '0;
      wr_clr  = '0;
      mreq    = '0;
      cin     = 1'b0;
      map     = '0;
      excl    = (st_reg.clk_base >= CLKBASE_DIV_LO); // [RULE_08]

      // Pack enabled units onto consecutive lines
      pos = {1'b0, st_reg.offset}; // [RULE_02] [RULE_05]
      for (int u = 0; u < N_UNITS; u++)
      begin
         act[u]  = st_reg.en[u]
                && !((u == UNIT_CTRA) && excl); // [RULE_01] [RULE_07]
         slot[u] = pos[3:0];
         if (act[u])
            pos = pos + 5'h01; // [RULE_04]
         map[4*u +: 4] = act[u] ? slot[u] : LINE_NONE;
      end

      // Falling edge counters
      for (int c = 0; c < 2; c++)
      begin
         cin     = line_in[slot[UNIT_CTRA + c]];
         fall[c] = act[UNIT_CTRA + c] && st_reg.prev[c] && !cin;
         st_next.prev[c] = act[UNIT_CTRA + c] ? cin : 1'b0;
         if (fall[c])
         begin
            st_next.count[c] = st_reg.count[c] + 32'h1; // [RULE_12]
            if (st_reg.count[c] == '1)
               ev[IRQ_CTRA_WRAP + c] = 1'b1;
         end
      end

      // Write data phase
      if (st_reg.wr_pend)
      begin
         if (st_reg.wr_addr == OFS_CTRL)
         begin
            st_next.en = hwdata[N_UNITS-1:0]; // [RULE_01]
            if (hwdata[UNIT_CTRA] && excl)
            begin
               st_next.en[UNIT_CTRA] = 1'b0; // [RULE_09]
               ev[IRQ_CTRA_CONFLICT] = 1'b1;
            end
         end
         else if (st_reg.wr_addr == OFS_PIN_OFFSET)
         begin
            if ((hwdata[31:4] == '0) && (hwdata[3:0] <= OFFSET_MAX))
               st_next.offset = hwdata[3:0]; // [RULE_03]
            else
               ev[IRQ_RANGE_BAD] = 1'b1;
         end
         else if (st_reg.wr_addr == OFS_CLK_BASE)
         begin
            if ((hwdata[31:3] != '0) || (hwdata[2:0] > CLKBASE_MAX))
               ev[IRQ_RANGE_BAD] = 1'b1;
            else if ((hwdata[2:0] >= CLKBASE_DIV_LO)
                     && st_reg.en[UNIT_CTRA])
               ev[IRQ_CLK_CONFLICT] = 1'b1; // [RULE_10]
            else
               st_next.clk_base = hwdata[2:0];
         end
         else if (st_reg.wr_addr == OFS_MODES)
         begin
            for (int t = 0; t < N_TIMERS; t++)
            begin
               mreq = hwdata[4*t +: 4];
               // [RULE_14] [RULE_15] [RULE_17]
               if ((mreq > MODE_LINE_TO_LINE)
                   || ((mreq == MODE_TIMER_STOP) && (t % 2 == 0)))
                  ev[IRQ_RANGE_BAD] = 1'b1; // [RULE_16]
               else
                  st_next.modes[t] = mreq;
            end
         end
         else if (st_reg.wr_addr == OFS_LINE_DIR)
         begin
            st_next.dir = hwdata[N_LINES-1:0];
         end
         else if (st_reg.wr_addr == OFS_LINE_OUT)
         begin
            st_next.gp_out = hwdata[N_LINES-1:0];
         end
         else if (st_reg.wr_addr == OFS_IRQ_CLR)
         begin
            wr_clr = hwdata[IRQ_W-1:0];
         end
         else if (st_reg.wr_addr == OFS_IRQ_EN)
         begin
            st_next.irq_en = hwdata[IRQ_W-1:0];
         end
      end

      // Claimed lines take the unit's direction; it stays once released
      st_next.lout = st_next.gp_out; // [RULE_06]
      for (int u = 0; u < N_UNITS; u++)
      begin
         if (act[u])
         begin
            st_next.dir[slot[u]] = want_out[u]; // [RULE_11]
            if (want_out[u])
               st_next.lout[slot[u]] = wave_all[u];
         end
      end

      // Set wins over clear
      st_next.irq_st = (st_reg.irq_st & ~wr_clr) | ev;
      st_next.irq    = |(st_next.irq_st & st_next.irq_en);

      // Address phase
      st_next.wr_pend = 1'b0;
      req_ok  = hsel && htrans[1] && hready;
      addr_ok = (haddr[31:ADDR_W] == '0);
      if (req_ok)
      begin
         st_next.wr_pend = hwrite && addr_ok;
         st_next.wr_addr = haddr[ADDR_W-1:0];
         if (!hwrite)
         begin
            st_next.rdata = '0;
            if (!addr_ok)
               st_next.rdata = '0;
            else if (haddr[ADDR_W-1:0] == OFS_CTRL)
               st_next.rdata[N_UNITS-1:0] = st_next.en;
            else if (haddr[ADDR_W-1:0] == OFS_PIN_OFFSET)
               st_next.rdata[3:0] = st_next.offset;
            else if (haddr[ADDR_W-1:0] == OFS_CLK_BASE)
               st_next.rdata[2:0] = st_next.clk_base;
            else if (haddr[ADDR_W-1:0] == OFS_MODES)
               st_next.rdata[MODE_W*N_TIMERS-1:0] = st_next.modes;
            else if (haddr[ADDR_W-1:0] == OFS_LINE_DIR)
               st_next.rdata[N_LINES-1:0] = st_next.dir;
            else if (haddr[ADDR_W-1:0] == OFS_LINE_OUT)
               st_next.rdata[N_LINES-1:0] = st_next.gp_out;
            else if (haddr[ADDR_W-1:0] == OFS_LINE_IN)
               st_next.rdata[N_LINES-1:0] = line_in;
            else if (haddr[ADDR_W-1:0] == OFS_LINE_MAP)
               st_next.rdata[4*N_UNITS-1:0] = map;
            else if (haddr[ADDR_W-1:0] == OFS_CNT_A)
               st_next.rdata = st_reg.count[0]; // [RULE_18]
            else if (haddr[ADDR_W-1:0] == OFS_CNT_B)
               st_next.rdata = st_reg.count[1]; // [RULE_18]
            else if (haddr[ADDR_W-1:0] == OFS_CNT_A_RC)
            begin
               st_next.rdata    = st_reg.count[0]; // [RULE_13]
               st_next.count[0] = fall[0] ? 32'h1 : 32'h0;
            end
            else if (haddr[ADDR_W-1:0] == OFS_CNT_B_RC)
            begin
               st_next.rdata    = st_reg.count[1]; // [RULE_13]
               st_next.count[1] = fall[1] ? 32'h1 : 32'h0;
            end
            else if (haddr[ADDR_W-1:0] == OFS_IRQ_STAT)
               st_next.rdata[IRQ_W-1:0] = st_reg.irq_st;
            else if (haddr[ADDR_W-1:0] == OFS_IRQ_EN)
               st_next.rdata[IRQ_W-1:0] = st_next.irq_en;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_reg <= ST_RST;
      else
         st_reg <= st_next;
   end

endmodule // tcp_timer_counter

`default_nettype wire

// *** tcp_pkg.sv ***
// Constants and types for the timer and counter line allocator
package tcp_pkg;

   // Unit and line counts
   localparam int unsigned N_TIMERS     = 4;
   localparam int unsigned N_UNITS      = 6;
   localparam int unsigned N_LINES      = 16;
   localparam int unsigned N_FLEX       = 8;
   localparam int unsigned CNT_W        = 32;
   localparam int unsigned MODE_W       = 4;
   localparam int unsigned ADDR_W       = 8;
   localparam int unsigned UNIT_CTRA    = 4;
   localparam int unsigned UNIT_CTRB    = 5;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_PIN_OFFSET = 8'h04;
   localparam logic [7:0] OFS_CLK_BASE   = 8'h08;
   localparam logic [7:0] OFS_MODES      = 8'h0C;
   localparam logic [7:0] OFS_LINE_DIR   = 8'h10;
   localparam logic [7:0] OFS_LINE_OUT   = 8'h14;
   localparam logic [7:0] OFS_LINE_IN    = 8'h18;
   localparam logic [7:0] OFS_LINE_MAP   = 8'h1C;
   localparam logic [7:0] OFS_CNT_A      = 8'h20;
   localparam logic [7:0] OFS_CNT_B      = 8'h24;
   localparam logic [7:0] OFS_CNT_A_RC   = 8'h28;
   localparam logic [7:0] OFS_CNT_B_RC   = 8'h2C;
   localparam logic [7:0] OFS_IRQ_STAT   = 8'h30;
   localparam logic [7:0] OFS_IRQ_CLR    = 8'h34;
   localparam logic [7:0] OFS_IRQ_EN     = 8'h38;

   // Limits and clock base classes
   localparam logic [3:0] OFFSET_MAX     = 4'h8;
   localparam logic [2:0] CLKBASE_MAX    = 3'h6;
   localparam logic [2:0] CLKBASE_DIV_LO = 3'h3;
   localparam logic [3:0] LINE_NONE      = 4'hF;

   // Timer mode encodings
   localparam logic [3:0] MODE_PWM16      = 4'h0;
   localparam logic [3:0] MODE_PWM8       = 4'h1;
   localparam logic [3:0] MODE_PER32_RISE = 4'h2;
   localparam logic [3:0] MODE_PER32_FALL = 4'h3;
   localparam logic [3:0] MODE_DUTY_IN    = 4'h4;
   localparam logic [3:0] MODE_FW_COUNT   = 4'h5;
   localparam logic [3:0] MODE_FW_DEBOUNCE = 4'h6;
   localparam logic [3:0] MODE_FREQ_OUT   = 4'h7;
   localparam logic [3:0] MODE_QUADRATURE = 4'h8;
   localparam logic [3:0] MODE_TIMER_STOP = 4'h9;
   localparam logic [3:0] MODE_SYS_LOW    = 4'hA;
   localparam logic [3:0] MODE_SYS_HIGH   = 4'hB;
   localparam logic [3:0] MODE_PER16_RISE = 4'hC;
   localparam logic [3:0] MODE_PER16_FALL = 4'hD;
   localparam logic [3:0] MODE_LINE_TO_LINE = 4'hE;

   // Interrupt status bit positions
   localparam int unsigned IRQ_W             = 5;
   localparam int unsigned IRQ_CTRA_CONFLICT = 0;
   localparam int unsigned IRQ_CLK_CONFLICT  = 1;
   localparam int unsigned IRQ_RANGE_BAD     = 2;
   localparam int unsigned IRQ_CTRA_WRAP     = 3;

   // Reset values
   localparam logic [2:0] CLKBASE_RST = 3'h2;
   localparam logic [3:0] MODE_RST    = MODE_SYS_LOW;

   typedef struct packed {
      logic [N_UNITS-1:0]              en;
      logic [3:0]                      offset;
      logic [2:0]                      clk_base;
      logic [N_TIMERS-1:0][MODE_W-1:0] modes;
      logic [N_LINES-1:0]              dir;
      logic [N_LINES-1:0]              gp_out;
      logic [N_LINES-1:0]              lout;
      logic [1:0][CNT_W-1:0]           count;
      logic [1:0]                      prev;
      logic [IRQ_W-1:0]                irq_st;
      logic [IRQ_W-1:0]                irq_en;
      logic                            irq;
      logic [31:0]                     rdata;
      logic                            wr_pend;
      logic [ADDR_W-1:0]               wr_addr;
   } tcp_state_t;

   localparam tcp_state_t ST_RST = '{
      clk_base: CLKBASE_RST,
      modes:    {N_TIMERS{MODE_RST}},
      default:  '0
   };

endpackage

// *** tcp_timer_counter_monitor.sv ***
// Bus and line assertions for the timer and counter allocator
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_counter_monitor
   import tcp_pkg::*;
(
   input wire logic               hclk,      // Bus clock
   input wire logic               hresetn,   // Reset, active low
   input wire logic               hsel,      // Slave select
   input wire logic [31:0]        haddr,     // Byte address
   input wire logic [1:0]         htrans,    // Transfer type
   input wire logic               hwrite,    // Write flag
   input wire logic               hready,    // Bus ready
   input wire logic [31:0]        hrdata,    // Read data
   input wire logic               hreadyout, // Slave ready
   input wire logic               hresp,     // Response
   input wire logic [N_LINES-1:0] line_in,   // Line levels
   input wire logic [N_LINES-1:0] line_oe,   // Line enables
   input wire logic               irq        // Interrupt
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd_tk;
   logic wr_tk;
   logic rc_b;
   assign rd_tk = hsel & htrans[1] & hready & !hwrite;
   assign wr_tk = hsel & htrans[1] & hready & hwrite;
   assign rc_b  = rd_tk && haddr == {24'h0, OFS_CNT_B_RC};
   a_ready_one: assert property (hreadyout == 1'b1)
      else $error("hreadyout low");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   a_rdata_hold: assert property (!$past(rd_tk) |-> $stable(hrdata))
      else $error("hrdata moved without a read");
   a_unmapped_zero: assert property
      (rd_tk && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_line_in_read: assert property
      (rd_tk && haddr == {24'h0, OFS_LINE_IN} && $stable(line_in)
       |=> hrdata == {16'h0, $past(line_in)})
      else $error("line level read wrong");
   a_oe_cause: assert property
      (!$stable(line_oe) |-> $past(wr_tk) || $past(wr_tk, 2)
       || $past(wr_tk, 3))
      else $error("line direction moved without a write");
   a_irq_cause: assert property
      (!$stable(irq) |-> $past(wr_tk) || $past(wr_tk, 2)
       || $past(wr_tk, 3))
      else $error("irq moved without a write");
   a_rc_clears: assert property
      ((rc_b && $stable(line_in)) ##1 $stable(line_in)
       ##1 (rc_b && $stable(line_in))
       |=> hrdata == 32'h0)
      else $error("read and reset left a count");
endmodule // tcp_timer_counter_monitor
bind tcp_timer_counter tcp_timer_counter_monitor tcp_timer_counter_monitor_i
   (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .line_in(line_in),
    .line_oe(line_oe), .irq(irq));
`default_nettype wire

// *** tcp_line_src.sv ***
// External signal source on the I/O lines, passing ext_lvl where the device does not drive
`timescale 1ns/1ps
`default_nettype none
module tcp_line_src
   import tcp_pkg::*;
(
   input wire logic [N_LINES-1:0] line_oe,  // Device drive enables
   input wire logic [N_LINES-1:0] line_out, // Device drive levels
   input wire logic [N_LINES-1:0] ext_lvl,  // External source levels
   output logic [N_LINES-1:0]     line_in   // Resolved line levels
);
   assign line_in = (line_oe & line_out) | (~line_oe & ext_lvl);
endmodule // tcp_line_src
`default_nettype wire

// *** tcp_timer_counter_tb.sv ***
// Self-checking testbench for the timer and counter allocator
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_counter_tb
   import tcp_pkg::*;
;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [1:0] htrans = 0;
   logic [23:0] ahi = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [3:0] timer_wave = 0;
   logic [15:0] ext_lvl = 16'hFFFF, line_in, line_out, line_oe;
   logic hreadyout, hresp, irq;
   int miscompares = 0, n_compared = 0;
   always #10 hclk = ~hclk;
   tcp_timer_counter tcp_timer_counter_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .line_in(line_in),
      .line_out(line_out), .line_oe(line_oe), .timer_wave(timer_wave),
      .irq(irq));
   tcp_line_src tcp_line_src_i (.line_oe(line_oe), .line_out(line_out),
      .ext_lvl(ext_lvl), .line_in(line_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {ahi, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic t_reset;
      rdc(OFS_CTRL, 32'h0);
      rdc(OFS_MODES, 32'hAAAA);
      rdc(OFS_LINE_MAP, 32'hFFFFFF);
      rdc(8'h40, 32'h0);
      ahi = 24'h1;
      rdc(OFS_CLK_BASE, 32'h0);
      ahi = 24'h0;
      $display("test reset done");
   endtask
   task automatic t_alloc;
      logic [5:0] en[4] = '{6'h01, 6'h21, 6'h33, 6'h3F};
      logic [3:0] of[4] = '{4'h0, 4'h0, 4'h8, 4'h8};
      logic [23:0] mp[4] = '{24'hFFFFF0, 24'h1FFFF0, 24'hBAFF98, 24'hDCBA98};
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_PIN_OFFSET, {28'h0, of[i]});
         wr(OFS_CTRL, {26'h0, en[i]});
         @(posedge hclk);
         rdc(OFS_LINE_MAP, {8'h0, mp[i]});
      end
      wr(OFS_PIN_OFFSET, 32'h9);
      @(posedge hclk);
      rdc(OFS_PIN_OFFSET, 32'h8);
      rdc(OFS_IRQ_STAT, 32'h4);
      wr(OFS_IRQ_CLR, 32'h1F);
      wr(OFS_CTRL, 32'h0);
      $display("test alloc done");
   endtask
   task automatic t_clock;
      wr(OFS_IRQ_EN, 32'h3);
      wr(OFS_CTRL, 32'h10);
      wr(OFS_CLK_BASE, 32'h3);
      @(posedge hclk);
      rdc(OFS_CLK_BASE, 32'h2);
      rdc(OFS_IRQ_STAT, 32'h2);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_IRQ_EN, 32'h0);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_IRQ_CLR, 32'h1F);
      wr(OFS_IRQ_EN, 32'h3);
      wr(OFS_CTRL, 32'h0);
      for (int b = 3; b < 7; b++)
      begin
         wr(OFS_CLK_BASE, b);
         rdc(OFS_CLK_BASE, b);
      end
      wr(OFS_CTRL, 32'h30);
      @(posedge hclk);
      rdc(OFS_CTRL, 32'h20);
      rdc(OFS_LINE_MAP, 32'h8FFFFF);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_IRQ_CLR, 32'h1F);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_CLK_BASE, 32'h0);
      wr(OFS_CTRL, 32'h10);
      rdc(OFS_CTRL, 32'h10);
      wr(OFS_CTRL, 32'h0);
      $display("test clock base done");
   endtask
   task automatic t_count;
      wr(OFS_PIN_OFFSET, 32'h0);
      wr(OFS_CTRL, 32'h20);
      repeat (3)
      begin
         @(posedge hclk);
         ext_lvl[0] <= 1'b0;
         @(posedge hclk);
         ext_lvl[0] <= 1'b1;
      end
      repeat (2) @(posedge hclk);
      chk({31'h0, line_oe[0]}, 32'h0);
      rdc(OFS_CNT_B, 32'h3);
      rdc(OFS_CNT_B_RC, 32'h3);
      rdc(OFS_CNT_B_RC, 32'h0);
      rdc(OFS_CNT_A, 32'h0);
      $display("test counter done");
   endtask
   task automatic t_dir;
      wr(OFS_CTRL, 32'h0);
      wr(OFS_MODES, 32'hAAA0);
      wr(OFS_LINE_DIR, 32'h20);
      wr(OFS_LINE_OUT, 32'h20);
      wr(OFS_CTRL, 32'h1);
      timer_wave <= 4'h1;
      repeat (3) @(posedge hclk);
      chk({28'h0, line_oe[5], line_out[5], line_oe[0], line_out[0]},
          32'hF);
      wr(OFS_CTRL, 32'h0);
      repeat (3) @(posedge hclk);
      chk({31'h0, line_oe[0]}, 32'h1);
      rdc(OFS_LINE_IN, 32'hFFFE);
      $display("test direction done");
   endtask
   task automatic t_modes;
      logic [15:0] cur = 16'hAAA0;
      for (int m = 0; m < 16; m++)
      begin
         wr(OFS_MODES, {16'h0, {4{m[3:0]}}});
         for (int t = 0; t < 4; t++)
            if (m < 15 && !(m == 9 && t % 2 == 0))
               cur[4*t +: 4] = m[3:0];
         rdc(OFS_MODES, {16'h0, cur});
      end
      $display("test modes done");
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_alloc;
      t_clock;
      t_count;
      t_dir;
      t_modes;
      stop_test;
   end
   initial
   begin
      repeat (20000) @(posedge hclk);
      miscompares++;
      stop_test;
   end
endmodule // tcp_timer_counter_tb
`default_nettype wire
